// >>> core/lac_pkg.sv
// Constants, field layout and types shared by the locality access arbiter
package lac_pkg;

  // ----------------------------------------------------------------
  // Locality set and register shape
  // ----------------------------------------------------------------
  localparam int unsigned NUM_LOC = 5;
  localparam int unsigned LOC_W   = 3;
  localparam int unsigned REG_W   = 8;

  // ----------------------------------------------------------------
  // Field positions of the locality access control register
  // ----------------------------------------------------------------
  localparam int unsigned BIT_REG_VALID     = 7;
  localparam int unsigned BIT_RESERVED      = 6;
  localparam int unsigned BIT_LOC_ACTIVE    = 5;
  localparam int unsigned BIT_SEIZED        = 4;
  localparam int unsigned BIT_TAKEOVER      = 3;
  localparam int unsigned BIT_OTHER_PENDING = 2;
  localparam int unsigned BIT_USE_REQUEST   = 1;
  localparam int unsigned BIT_LAUNCH_ABSENT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] RDATA_RESET   = 8'h00;
  localparam logic             LAUNCH_RESET  = 1'b1;

  // ----------------------------------------------------------------
  // Timing: clock period and the register-valid limit after reset
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned VALID_TIME_NS = 1000;
  // Longest time, so round down; never below one cycle
  localparam int unsigned VALID_CYCLES  =
    (VALID_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 : (VALID_TIME_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Host port sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_READY = 2'h1,
    ST_STALL = 2'h2
  } lac_state_t;

endpackage : lac_pkg

// >>> core/lac_prio_pick.sv
// Highest-index picker over the per-locality request vector
module lac_prio_pick #(
  parameter int unsigned N = 5,
  parameter int unsigned W = 3
) (
  input  wire logic [N-1:0] req_in,
  output logic              any_out,
  output logic [W-1:0]      idx_out
);

  // Later indices overwrite earlier ones, so the top locality wins
  always_comb begin
    any_out = 1'b0;
    idx_out = '0;
    for (int i = 0; i < N; i++) begin
      if (req_in[i]) begin
        any_out = 1'b1;
        idx_out = W'(i);
      end
    end
  end

endmodule : lac_prio_pick

// >>> core/lac_valid_timer.sv
// Post-reset timer that raises the register-valid level
module lac_valid_timer #(
  parameter int unsigned CYCLES = 250
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  output logic      done_out
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          done;
  } lac_tmr_t;

  lac_tmr_t cur_ff;
  lac_tmr_t nxt_st;

  // Count up once, then park with done held high
  always_comb begin
    nxt_st = cur_ff;
    if (cur_ff.cnt != CW'(CYCLES)) begin
      nxt_st.cnt = cur_ff.cnt + CW'(1);
    end
    nxt_st.done = (nxt_st.cnt == CW'(CYCLES));
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign done_out = cur_ff.done;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [CW:0] age_ff;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      age_ff <= '0;
    end else if (age_ff != (CW + 1)'(CYCLES + 1)) begin
      age_ff <= age_ff + (CW + 1)'(1);
    end
  end

  valid_in_time_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (age_ff >= (CW + 1)'(CYCLES)) |-> done_out)
    else $error("register valid late after reset");

  valid_not_early_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (age_ff < (CW + 1)'(CYCLES - 1)) |-> !done_out)
    else $error("register valid raised too early");

endmodule : lac_valid_timer

// >>> core/lac_locality_access_arbiter.sv
// Five-locality access control register and ownership arbiter
// Behaviour
// - Reserved bit ignores writes, reads zero
// - Active bit reads one only for owner
// - Owner writing active bit releases ownership
// - On release, highest requester becomes owner
// - Non-owner with request: active write cancels
// - Non-owner without request: active write ignored
// - Free device grants requester within short timeout
// - Busy device grants requester after owner releases
// - Seized flag set when takeover removes ownership
// - Writing one to seized flag clears it
// - Takeover write moves ownership to higher locality
// - Locality 0 takeover ignored unless device free
// - Takeover clears loser, flags seized, aborts command
// - Pending bit shows another locality requesting
// - Request bit set by write, reads while waiting
// - Launch flag resets one, persists across resets
// - Reads stall with wait states until valid
// - Valid never reported while fields undefined
// - Valid flag rises within reset timing limit
// - Fields written with zero are ignored
// - Takeover from equal or lower locality ignored
// - Request write raises pending for other localities
// - Top bit is read-only register valid flag
module lac_locality_access_arbiter
  import lac_pkg::*;
#(
  parameter int unsigned VALID_CYCLES_P = lac_pkg::VALID_CYCLES
) (
  input  wire logic                      CLOCK_IN,
  input  wire logic                      RESET_IN,
  input  wire logic                      REQ_IN,
  input  wire logic                      WRITE_IN,
  input  wire logic [lac_pkg::LOC_W-1:0] LOCALITY_IN,
  input  wire logic [lac_pkg::REG_W-1:0] WDATA_IN,
  input  wire logic                      LAUNCH_ABSENT_IN,
  input  wire logic                      LAUNCH_DONE_IN,
  output logic                           ACK_OUT,
  output logic                           WAIT_OUT,
  output logic      [lac_pkg::REG_W-1:0] RDATA_OUT,
  output logic                           OWNER_VALID_OUT,
  output logic      [lac_pkg::LOC_W-1:0] OWNER_OUT,
  output logic                           COMMAND_ABORT_OUT,
  output logic                           LAUNCH_ABSENT_OUT,
  output logic                           REG_VALID_OUT
);

  import lac_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    lac_state_t         state;
    logic [LOC_W-1:0]   hold_loc;
    logic               hold_we;
    logic [REG_W-1:0]   hold_data;
    logic               own_vld;
    logic [LOC_W-1:0]   owner;
    logic [NUM_LOC-1:0] req;
    logic [NUM_LOC-1:0] seized;
    logic               launch;
    logic               valid;
    logic               ack;
    logic               wait_s;
    logic [REG_W-1:0]   rdata;
    logic               abort;
    logic [LOC_W-1:0]   last_loc;
    logic               last_rd;
  } lac_st_t;

  localparam lac_st_t ST_RESET = '{state: ST_READY, launch: LAUNCH_RESET, default: '0};

  lac_st_t            cur_ff;
  lac_st_t            nxt_st;
  logic               timer_done;
  logic               pick_any;
  logic [LOC_W-1:0]   pick_idx;
  logic               do_acc;
  logic [LOC_W-1:0]   acc_loc;
  logic               acc_we;
  logic [REG_W-1:0]   acc_data;
  logic               acc_ok;
  logic [NUM_LOC-1:0] acc_mask;
  logic               is_owner;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  lac_valid_timer #(
    .CYCLES   (VALID_CYCLES_P)
  ) u_timer (
    .clk_in   (CLOCK_IN),
    .rst_in   (RESET_IN),
    .done_out (timer_done)
  );

  // Registered requests only, so no loop through the write logic
  lac_prio_pick #(
    .N       (NUM_LOC),
    .W       (LOC_W)
  ) u_pick (
    .req_in  (cur_ff.req),
    .any_out (pick_any),
    .idx_out (pick_idx)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st   = cur_ff;
    nxt_st.ack   = 1'b0;
    nxt_st.abort = 1'b0;
    nxt_st.valid = timer_done;
    do_acc   = 1'b0;
    acc_loc  = LOCALITY_IN;
    acc_we   = WRITE_IN;
    acc_data = WDATA_IN;

    // Host port: stall every access until the fields are defined
    case (cur_ff.state)
      ST_READY: begin
        if (REQ_IN) begin
          if (timer_done) begin
            do_acc = 1'b1;
          end else begin
            nxt_st.state     = ST_STALL;
            nxt_st.hold_loc  = LOCALITY_IN;
            nxt_st.hold_we   = WRITE_IN;
            nxt_st.hold_data = WDATA_IN;
            nxt_st.wait_s    = 1'b1;
          end
        end
      end
      ST_STALL: begin
        acc_loc  = cur_ff.hold_loc;
        acc_we   = cur_ff.hold_we;
        acc_data = cur_ff.hold_data;
        if (timer_done) begin
          do_acc        = 1'b1;
          nxt_st.state  = ST_READY;
          nxt_st.wait_s = 1'b0;
        end
      end
      default: begin
        nxt_st.state  = ST_READY;
        nxt_st.wait_s = 1'b0;
      end
    endcase

    // Launch flag follows the persistent store until valid rises
    if (!timer_done) begin
      nxt_st.launch = LAUNCH_ABSENT_IN;
    end else if (LAUNCH_DONE_IN) begin
      nxt_st.launch = 1'b0;
    end

    // Free device: hand it to the top requester
    if (!cur_ff.own_vld && pick_any) begin
      nxt_st.own_vld        = 1'b1;
      nxt_st.owner          = pick_idx;
      nxt_st.req[pick_idx]  = 1'b0;
    end

    acc_ok   = (acc_loc < LOC_W'(NUM_LOC));
    acc_mask = NUM_LOC'(1) << acc_loc;
    is_owner = nxt_st.own_vld && (nxt_st.owner == acc_loc);

    if (do_acc) begin
      nxt_st.ack      = 1'b1;
      nxt_st.last_loc = acc_loc;
      nxt_st.last_rd  = !acc_we;
      nxt_st.rdata    = RDATA_RESET;
      if (!acc_we && acc_ok) begin
        nxt_st.rdata[BIT_REG_VALID]     = timer_done;
        nxt_st.rdata[BIT_RESERVED]      = 1'b0;
        nxt_st.rdata[BIT_LOC_ACTIVE]    = is_owner;
        nxt_st.rdata[BIT_SEIZED]        = nxt_st.seized[acc_loc];
        nxt_st.rdata[BIT_TAKEOVER]      = 1'b0;
        nxt_st.rdata[BIT_OTHER_PENDING] = |(nxt_st.req & ~acc_mask);
        nxt_st.rdata[BIT_USE_REQUEST]   = nxt_st.req[acc_loc] && !is_owner;
        nxt_st.rdata[BIT_LAUNCH_ABSENT] = nxt_st.launch;
      end else if (acc_we && acc_ok) begin
        // Only bits written as one act; reserved bit has no effect
        if (acc_data[BIT_LOC_ACTIVE]) begin
          if (is_owner) begin
            nxt_st.own_vld = 1'b0;
            nxt_st.abort   = 1'b1;
          end else if (nxt_st.req[acc_loc]) begin
            nxt_st.req[acc_loc] = 1'b0;
          end
          // Else nothing happens at all
        end
        if (acc_data[BIT_SEIZED]) begin
          nxt_st.seized[acc_loc] = 1'b0;
        end
        if (acc_data[BIT_TAKEOVER]) begin
          if (!nxt_st.own_vld) begin
            nxt_st.own_vld      = 1'b1;
            nxt_st.owner        = acc_loc;
            nxt_st.req[acc_loc] = 1'b0;
          end else if (acc_loc > nxt_st.owner) begin
            nxt_st.seized[nxt_st.owner] = 1'b1;
            nxt_st.owner        = acc_loc;
            nxt_st.req[acc_loc] = 1'b0;
            nxt_st.abort        = 1'b1;
          end
          // Equal or lower locality, including zero, is ignored
        end
        if (acc_data[BIT_USE_REQUEST] && !is_owner) begin
          nxt_st.req[acc_loc] = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      cur_ff <= ST_RESET;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // Every output taken straight from the state register
  assign ACK_OUT           = cur_ff.ack;
  assign WAIT_OUT          = cur_ff.wait_s;
  assign RDATA_OUT         = cur_ff.rdata;
  assign OWNER_VALID_OUT   = cur_ff.own_vld;
  assign OWNER_OUT         = cur_ff.owner;
  assign COMMAND_ABORT_OUT = cur_ff.abort;
  assign LAUNCH_ABSENT_OUT = cur_ff.launch;
  assign REG_VALID_OUT     = cur_ff.valid;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (RESET_IN);

  logic wr_acc;
  logic own_wr;
  assign wr_acc = do_acc && acc_we && acc_ok;
  assign own_wr = cur_ff.own_vld && (cur_ff.owner == acc_loc);

  reserved_zero_a: assert property (ACK_OUT |-> !RDATA_OUT[BIT_RESERVED])
    else $error("reserved bit read as one");

  active_read_a: assert property (
    (ACK_OUT && cur_ff.last_rd && cur_ff.last_loc < LOC_W'(NUM_LOC)) |->
    (RDATA_OUT[BIT_LOC_ACTIVE] == (OWNER_VALID_OUT && OWNER_OUT == cur_ff.last_loc)))
    else $error("active bit does not match owner");

  release_a: assert property (
    (wr_acc && acc_data == 8'h20 && own_wr) |=>
    (!(OWNER_VALID_OUT && OWNER_OUT == $past(acc_loc)) && COMMAND_ABORT_OUT))
    else $error("owner release not honoured");

  handoff_a: assert property (
    (!OWNER_VALID_OUT && |cur_ff.req) |=> (OWNER_VALID_OUT && $past(pick_any)))
    else $error("free device not granted to requester");

  cancel_a: assert property (
    (wr_acc && acc_data == 8'h20 && !own_wr && cur_ff.own_vld && cur_ff.req[acc_loc])
    |=> !cur_ff.req[$past(acc_loc)])
    else $error("request not withdrawn");

  takeover_a: assert property (
    (wr_acc && acc_data == 8'h08 && cur_ff.own_vld && acc_loc > cur_ff.owner) |=>
    (cur_ff.seized[$past(cur_ff.owner)] && COMMAND_ABORT_OUT &&
     OWNER_OUT == $past(acc_loc)))
    else $error("takeover did not complete");

  low_takeover_a: assert property (
    (wr_acc && acc_data == 8'h08 && cur_ff.own_vld && acc_loc <= cur_ff.owner) |=>
    ($stable(OWNER_OUT) && OWNER_VALID_OUT && !COMMAND_ABORT_OUT))
    else $error("low takeover changed owner");

  seized_clear_a: assert property (
    (wr_acc && acc_data == 8'h10) |=> !cur_ff.seized[$past(acc_loc)])
    else $error("seized flag not cleared");

  pending_read_a: assert property (
    (ACK_OUT && cur_ff.last_rd && cur_ff.last_loc < LOC_W'(NUM_LOC)) |->
    (RDATA_OUT[BIT_OTHER_PENDING] ==
     |(cur_ff.req & ~(NUM_LOC'(1) << cur_ff.last_loc))))
    else $error("pending bit wrong");

  // Reads complete only once fields are defined, and then report valid
  valid_answer_a: assert property (
    (ACK_OUT && cur_ff.last_rd && cur_ff.last_loc < LOC_W'(NUM_LOC)) |->
    (RDATA_OUT[BIT_REG_VALID] && REG_VALID_OUT))
    else $error("read answered before fields defined");

  stall_a: assert property ((REQ_IN && cur_ff.state == ST_READY && !timer_done) |=>
    (WAIT_OUT && !ACK_OUT))
    else $error("access not stalled before valid");

  grant_cov: cover property (!OWNER_VALID_OUT ##1 OWNER_VALID_OUT);
  seize_cov: cover property (wr_acc && acc_data == 8'h08 && cur_ff.own_vld);
  stall_cov: cover property (WAIT_OUT ##1 !WAIT_OUT ##1 ACK_OUT);

endmodule : lac_locality_access_arbiter

// >>> verif/lac_host_model.sv
// Host software model issuing locality register accesses
module lac_host_model (
  input  wire logic                      clk_in,
  input  wire logic                      ack_in,
  input  wire logic                      wait_in,
  input  wire logic                      abort_in,
  input  wire logic [lac_pkg::REG_W-1:0] rdata_in,
  output logic                           req_out,
  output logic                           write_out,
  output logic      [lac_pkg::LOC_W-1:0] loc_out,
  output logic      [lac_pkg::REG_W-1:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import lac_pkg::*;

  // Idle bus at time zero
  initial begin
    req_out   = 1'b0;
    write_out = 1'b0;
    loc_out   = 3'h0;
    wdata_out = 8'h00;
  end

  // One-cycle request; qualifiers turn to their inverse once released
  // so a stale value can never pass for a real one
  task automatic access(input logic w, input logic [2:0] loc, input logic [7:0] wd,
                        output logic [7:0] rd, output logic ab, output logic wt);
    wt = 1'b0;
    @(negedge clk_in);
    req_out   <= 1'b1;
    write_out <= w;
    loc_out   <= loc;
    wdata_out <= wd;
    @(negedge clk_in);
    req_out   <= 1'b0;
    write_out <= ~w;
    loc_out   <= ~loc;
    wdata_out <= ~wd;
    // A lost ack waits here, so the bench hang guard fails the run
    // rather than a stale read slipping through; stall cycles noted
    while (ack_in !== 1'b1) begin
      wt = wt | (wait_in === 1'b1);
      @(negedge clk_in);
    end
    rd = rdata_in;
    ab = abort_in;
  endtask : access
endmodule : lac_host_model

// >>> verif/testbench.sv
// Self-checking bench for the locality access arbiter
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import lac_pkg::*;

  logic       clock_in   = 1'b0;
  logic       reset_in   = 1'b1;
  logic       launch_in  = 1'b1;
  logic       launch_done = 1'b0;
  logic       req, wr, ack, stall, own_valid, abort, launch_out, reg_valid;
  logic [2:0] loc, own;
  logic [7:0] wdata, rdata, rd;
  logic       ab, wt;
  int         fail_count  = 0;
  int         checks_done = 0;
  int         cycles      = 0;

  // 4 ns clock
  always #2 clock_in = ~clock_in;

  // Short valid delay keeps the stall phase brief
  lac_locality_access_arbiter #(.VALID_CYCLES_P(4)) lac_locality_access_arbiter_inst (
    .CLOCK_IN(clock_in), .RESET_IN(reset_in), .REQ_IN(req), .WRITE_IN(wr),
    .LOCALITY_IN(loc), .WDATA_IN(wdata), .LAUNCH_ABSENT_IN(launch_in),
    .LAUNCH_DONE_IN(launch_done), .ACK_OUT(ack), .WAIT_OUT(stall), .RDATA_OUT(rdata),
    .OWNER_VALID_OUT(own_valid), .OWNER_OUT(own), .COMMAND_ABORT_OUT(abort),
    .LAUNCH_ABSENT_OUT(launch_out), .REG_VALID_OUT(reg_valid));

  lac_host_model lac_host_model_inst (
    .clk_in(clock_in), .ack_in(ack), .wait_in(stall), .abort_in(abort),
    .rdata_in(rdata), .req_out(req), .write_out(wr), .loc_out(loc), .wdata_out(wdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Reads compare data; writes compare the abort pulse seen with the ack
  task automatic op(input logic w, input logic [2:0] l, input logic [7:0] wd,
                    input logic [7:0] exp);
    lac_host_model_inst.access(w, l, wd, rd, ab, wt);
    check(w ? {7'h00, ab} : rd, exp);
  endtask : op

  task automatic do_reset();
    @(negedge clock_in);
    reset_in = 1'b1;
    repeat (2) @(negedge clock_in);
    reset_in = 1'b0;
  endtask : do_reset

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  // Hang guard, far above the ninety or so cycles the run needs
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    // First read lands before the valid timer expires
    lac_host_model_inst.access(1'b0, 3'd0, 8'h00, rd, ab, wt);
    check({7'h00, wt}, 8'h01);
    check(rd, 8'h81);
    check({7'h00, reg_valid}, 8'h01);
    op(1'b1, 3'd0, 8'h40, 8'h00);
    op(1'b0, 3'd0, 8'h00, 8'h81);
    op(1'b1, 3'd1, 8'h20, 8'h00);
    check({4'h0, own_valid, own}, 8'h00);
    op(1'b1, 3'd2, 8'h02, 8'h00);
    op(1'b0, 3'd2, 8'h00, 8'hA1);
    check({4'h0, own_valid, own}, 8'h0A);
    op(1'b0, 3'd1, 8'h00, 8'h81);
    op(1'b1, 3'd0, 8'h02, 8'h00);
    op(1'b0, 3'd0, 8'h00, 8'h83);
    op(1'b0, 3'd2, 8'h00, 8'hA5);
    op(1'b1, 3'd3, 8'h02, 8'h00);
    op(1'b1, 3'd2, 8'h20, 8'h01);
    op(1'b0, 3'd2, 8'h00, 8'h85);
    op(1'b0, 3'd3, 8'h00, 8'hA5);
    op(1'b1, 3'd0, 8'h20, 8'h00);
    op(1'b0, 3'd0, 8'h00, 8'h81);
    op(1'b0, 3'd1, 8'h00, 8'h81);
    // Takeover attempts, then a real one from the top locality
    op(1'b1, 3'd0, 8'h08, 8'h00);
    op(1'b1, 3'd2, 8'h08, 8'h00);
    op(1'b1, 3'd3, 8'h08, 8'h00);
    check({4'h0, own_valid, own}, 8'h0B);
    // Abort pulse tells the seizer its command engine was reset
    op(1'b1, 3'd4, 8'h08, 8'h01);
    // Seizing software polls its active bit before use
    for (int i = 0; i < 8 && !rd[BIT_LOC_ACTIVE]; i++) begin
      lac_host_model_inst.access(1'b0, 3'd4, 8'h00, rd, ab, wt);
    end
    check(rd, 8'hA1);
    op(1'b0, 3'd3, 8'h00, 8'h91);
    op(1'b1, 3'd3, 8'h00, 8'h00);
    op(1'b0, 3'd3, 8'h00, 8'h91);
    op(1'b1, 3'd3, 8'h10, 8'h00);
    op(1'b0, 3'd3, 8'h00, 8'h81);
    op(1'b1, 3'd4, 8'h20, 8'h01);
    op(1'b1, 3'd0, 8'h08, 8'h00);
    op(1'b0, 3'd0, 8'h00, 8'hA1);
    op(1'b0, 3'd5, 8'h00, 8'h00);
    op(1'b1, 3'd1, 8'h02, 8'h00);
    op(1'b1, 3'd0, 8'h20, 8'h01);
    op(1'b0, 3'd1, 8'h00, 8'hA1);
    // Launch event clears the flag, which must survive a reset
    @(negedge clock_in);
    launch_done = 1'b1;
    @(negedge clock_in);
    launch_done = 1'b0;
    @(negedge clock_in);
    check({7'h00, launch_out}, 8'h00);
    op(1'b0, 3'd2, 8'h00, 8'h80);
    launch_in = 1'b0;
    do_reset();
    op(1'b0, 3'd1, 8'h00, 8'h80);
    complete_run();
  end
endmodule : testbench
